/* core/reservation_ie_field_codec.sv */
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
module reservation_ie_field_codec (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // MAC timing from local control logic
    input wire logic superframe_tick,
    input wire logic [7:0] current_slot,
    // Quiet period outputs
    output logic tx_quiet,
    output logic regular_quiet_period_now
);
    import rsv_codec_pkg::*;

    // ------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic take;
    assign take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            wr_ofs <= haddr[7:0];
        end
    end

    logic wr_en;
    assign wr_en = wr_pend;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [2:0] res_type;
    logic [2:0] stream_index;
    logic [2:0] reason;
    logic established;
    logic active;
    logic [15:0] owner_address;
    logic [15:0] target_address;
    logic [15:0] zone_bitmap;
    logic [15:0] slot_bitmap;
    logic [15:0] limit_zones;
    logic [15:0] limit_slots;
    logic [15:0] rx_zone_bitmap;
    logic [15:0] rx_slot_bitmap;
    logic [7:0] query_slot;
    logic [5:0] avail_len;
    logic [31:0] avail_mem [AVAIL_WORDS];
    logic [23:0] link_record;
    logic [7:0] link_count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_type <= RT_HARD;
            stream_index <= 3'h0;
            reason <= 3'h0;
            established <= 1'b0;
            active <= 1'b0;
        end else if (wr_en && wr_ofs == OFS_CTRL) begin
            res_type <= hwdata[CTL_TYPE_LSB +: 3];
            stream_index <= hwdata[CTL_STREAM_LSB +: 3];
            reason <= hwdata[CTL_REASON_LSB +: 3];
            established <= hwdata[CTRL_EST_BIT];
            active <= hwdata[CTRL_ACTIVE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            owner_address <= 16'h0000;
            target_address <= 16'h0000;
            zone_bitmap <= 16'h0000;
            slot_bitmap <= 16'h0000;
            limit_zones <= LIMIT_RESET[15:0];
            limit_slots <= LIMIT_RESET[31:16];
        end else if (wr_en) begin
            if (wr_ofs == OFS_ADDR) begin
                owner_address <= hwdata[15:0];
                target_address <= hwdata[31:16];
            end
            if (wr_ofs == OFS_ALLOC) begin
                zone_bitmap <= hwdata[15:0];
                slot_bitmap <= hwdata[31:16];
            end
            if (wr_ofs == OFS_LIMIT) begin
                limit_zones <= hwdata[15:0];
                limit_slots <= hwdata[31:16];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_zone_bitmap <= 16'h0000;
            rx_slot_bitmap <= 16'h0000;
            query_slot <= 8'h00;
            avail_len <= 6'h00;
            link_record <= 24'h000000;
            link_count <= 8'h00;
        end else if (wr_en) begin
            if (wr_ofs == OFS_RX_ALLOC) begin
                rx_zone_bitmap <= hwdata[15:0];
                rx_slot_bitmap <= hwdata[31:16];
            end
            if (wr_ofs == OFS_QUERY) begin
                query_slot <= hwdata[7:0];
            end
            if (wr_ofs == OFS_AVAIL_LEN) begin
                // Longer lengths saturate at the full bitmap
                avail_len <= (hwdata[7:0] > 8'(AVAIL_MAX_OCTETS)) ?
                    AVAIL_MAX_OCTETS : hwdata[5:0];
            end
            if (wr_ofs == OFS_LINK) begin
                link_record <= hwdata[23:0];
            end
            if (wr_ofs == OFS_LINK_CNT) begin
                link_count <= hwdata[7:0];
            end
        end
    end

    // Availability bitmap storage, one word per 32 slots
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < AVAIL_WORDS; i++) begin
                avail_mem[i] <= 32'h0000_0000;
            end
        end else if (wr_en && wr_ofs[7:5] == OFS_AVAIL0[7:5]) begin
            avail_mem[wr_ofs[4:2]] <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // Tie-breaker
    // ------------------------------------------------------------
    // A free-running LFSR is the random source; the draw is taken
    // only when a request starts so the bit stays fixed afterwards.
    logic [15:0] lfsr;
    logic tie_breaker;
    logic tie_held;
    logic req_strobe;
    assign req_strobe = wr_en && wr_ofs == OFS_CTRL && hwdata[CTRL_REQ_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfsr <= LFSR_SEED;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tie_breaker <= 1'b0;
            tie_held <= 1'b0;
        end else if (req_strobe && !tie_held) begin
            tie_breaker <= lfsr[0];
            tie_held <= 1'b1;
        end else if (wr_en && wr_ofs == OFS_CTRL && !hwdata[CTRL_ACTIVE_BIT]) begin
            tie_held <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channel reservation control word encode
    // ------------------------------------------------------------
    logic res_status;
    logic unsafe;
    logic is_prio;
    logic [15:0] rsv_word;
    assign is_prio = res_type == RT_PRIO;
    assign res_status = established || res_type == RT_ALIEN || is_prio;
    assign unsafe = |(zone_bitmap & ~limit_zones) ||
        (|zone_bitmap && |(slot_bitmap & ~limit_slots));

    // Every element of the reservation reads the same held tie bit
    assign rsv_word = {4'h0, unsafe, tie_breaker, res_status,
        reason, stream_index, res_type};

    // ------------------------------------------------------------
    // Received allocation, availability and link decode
    // ------------------------------------------------------------
    logic query_reserved;
    logic query_available;
    logic [31:0] avail_masked [AVAIL_WORDS];
    logic power_valid;
    logic [2:0] power_db;
    logic [9:0] link_len;

    // Slot number = zone * 16 + slot within zone
    assign query_reserved = rx_zone_bitmap[query_slot[7:4]] &&
        rx_slot_bitmap[query_slot[3:0]];

    for (genvar w = 0; w < AVAIL_WORDS; w++) begin : g_avail
        for (genvar b = 0; b < 4; b++) begin : g_byte
            assign avail_masked[w][8*b +: 8] =
                (6'(4*w + b) < avail_len) ? avail_mem[w][8*b +: 8] : 8'h00;
        end
    end

    assign query_available = avail_masked[query_slot[7:5]][query_slot[4:0]];

    always_comb begin
        power_valid = 1'b1;
        unique case (link_record[19:16])
            PW_M2: power_db = 3'b110;
            PW_M1: power_db = 3'b111;
            PW_0: power_db = 3'b000;
            PW_P1: power_db = 3'b001;
            PW_P2: power_db = 3'b010;
            default: begin
                power_db = 3'b000;
                power_valid = 1'b0;
            end
        endcase
    end

    assign link_len = 10'd1 + 10'd3 * {2'b00, link_count};

    // ------------------------------------------------------------
    // Quiet period schedules
    // ------------------------------------------------------------
    logic [7:0] reg_countdown;
    logic [7:0] reg_cycle;
    logic [7:0] reg_duration;
    logic [7:0] od_countdown;
    logic [7:0] od_start;
    logic [7:0] od_duration;
    logic od_valid;

    // Regular schedule reloads to cycle minus one after a zero-countdown frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_countdown <= 8'h00;
            reg_cycle <= 8'h00;
            reg_duration <= 8'h00;
        end else if (wr_en && wr_ofs == OFS_REG_QUIET) begin
            reg_countdown <= hwdata[7:0];
            reg_cycle <= hwdata[15:8];
            reg_duration <= hwdata[23:16];
        end else if (superframe_tick && reg_cycle != 8'h00) begin
            if (reg_countdown != 8'h00) begin
                reg_countdown <= reg_countdown - 8'h01;
            end else begin
                reg_countdown <= reg_cycle - 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            od_countdown <= 8'h00;
            od_start <= 8'h00;
            od_duration <= 8'h00;
            od_valid <= 1'b0;
        end else if (wr_en && wr_ofs == OFS_OD_QUIET) begin
            od_countdown <= hwdata[7:0];
            od_start <= hwdata[15:8];
            od_duration <= hwdata[23:16];
            od_valid <= hwdata[31];
        end else if (superframe_tick && od_valid) begin
            if (od_countdown != 8'h00) begin
                od_countdown <= od_countdown - 8'h01;
            end else begin
                // A one-shot quiet period is done once its frame ends
                od_valid <= 1'b0;
            end
        end
    end

    logic [8:0] od_end;
    logic [8:0] reg_end;
    assign od_end = {1'b0, od_start} + {1'b0, od_duration};
    assign reg_end = {1'b0, reg_duration};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_quiet <= 1'b0;
            regular_quiet_period_now <= 1'b0;
        end else begin
            tx_quiet <= od_valid && od_countdown == 8'h00 &&
                current_slot >= od_start && {1'b0, current_slot} < od_end;
            // Regular quiet period sits at the start of its superframe
            regular_quiet_period_now <= reg_cycle != 8'h00 &&
                reg_countdown == 8'h00 && {1'b0, current_slot} < reg_end;
        end
    end

    // ------------------------------------------------------------
    // Read mux and bus response
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (haddr[7:5] == OFS_AVAIL0[7:5]) begin
            next_rdata = avail_masked[haddr[4:2]];
        end else begin
            unique case (haddr[7:0])
                OFS_CTRL: next_rdata = {19'h0, active, rsv_word[11:0]};
                // Addresses read as zero for the prioritized type
                OFS_ADDR: next_rdata = is_prio ? 32'h0 :
                    {target_address, owner_address};
                OFS_ALLOC: next_rdata = {slot_bitmap, zone_bitmap};
                OFS_RSV_WORD: next_rdata = {16'h0, rsv_word};
                OFS_LIMIT: next_rdata = {limit_slots, limit_zones};
                OFS_RX_ALLOC: next_rdata = {rx_slot_bitmap, rx_zone_bitmap};
                OFS_QUERY: next_rdata = {24'h0, query_slot};
                OFS_STATUS: next_rdata = {20'h0, power_db, power_valid,
                    link_record[23:20], tie_held, od_valid,
                    query_available, query_reserved};
                OFS_AVAIL_LEN: next_rdata = {26'h0, avail_len};
                OFS_LINK: next_rdata = {8'h0, link_record};
                OFS_LINK_CNT: next_rdata = {14'h0, link_len, link_count};
                OFS_REG_QUIET: next_rdata = {8'h0, reg_duration, reg_cycle,
                    reg_countdown};
                OFS_OD_QUIET: next_rdata = {od_valid, 7'h0, od_duration, od_start,
                    od_countdown};
                OFS_LENGTHS: next_rdata = {16'h0, QUIET_LEN, RSV_LEN_ONE_ALLOC};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Zero-wait slave: read data is registered from the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (take && !hwrite) ? next_rdata : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : reservation_ie_field_codec

/* core/crp_codec_pkg.sv */
// What this block does
// - Status bit zero while negotiating or conflicting
// - Status bit one when granted or maintained
// - Status forced one for alien and prioritized types
// - Type field: 0 alien..4 prioritized, 5-7 reserved
// - Tie-breaker drawn randomly at reservation request
// - Tie-breaker held while reservation stays active
// - All elements of one reservation share tie-breaker
// - Owner/target addresses, reserved for prioritized type
// - Unsafe bit when allocation exceeds limits
// - Superframe has 16 zones from beacon start
// - Each zone has 16 slots numbered 0-15
// - Allocation field: zone bitmap then slot bitmap
// - Zone bitmap bit n flags zone n
// - Slot bitmap bit m reserves slot m per zone
// - Availability bitmap 256 bits, LSB first slot
// - Missing trailing availability octets read as zero
// - Link feedback length is 1+3xN
// - Link record: address, power change, data rate
// - Power change codes -2..+2 dB, others reserved
// - Regular quiet schedule always present, length 3
// - Regular countdown zero means this superframe
// - Sensing cycle zero means none scheduled
// - No transmit during received on-demand quiet period
// - On-demand: countdown, start slot, duration
package rsv_codec_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_ALLOC = 8'h08;
    localparam logic [7:0] OFS_RSV_WORD = 8'h0c;
    localparam logic [7:0] OFS_LIMIT = 8'h10;
    localparam logic [7:0] OFS_RX_ALLOC = 8'h14;
    localparam logic [7:0] OFS_QUERY = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_AVAIL_LEN = 8'h20;
    localparam logic [7:0] OFS_LINK = 8'h24;
    localparam logic [7:0] OFS_LINK_CNT = 8'h28;
    localparam logic [7:0] OFS_REG_QUIET = 8'h2c;
    localparam logic [7:0] OFS_OD_QUIET = 8'h30;
    localparam logic [7:0] OFS_LENGTHS = 8'h34;
    localparam logic [7:0] OFS_AVAIL0 = 8'h40;
    // ------------------------------------------------------------
    // Field positions in the control word
    // ------------------------------------------------------------
    localparam int CTL_TYPE_LSB = 0;
    localparam int CTL_STREAM_LSB = 3;
    localparam int CTL_REASON_LSB = 6;
    localparam int CTL_STATUS_BIT = 9;
    localparam int CTL_TIE_BIT = 10;
    localparam int CTL_UNSAFE_BIT = 11;
    // CTRL register write-side bits
    localparam int CTRL_EST_BIT = 9;
    localparam int CTRL_ACTIVE_BIT = 12;
    localparam int CTRL_REQ_BIT = 13;
    // ------------------------------------------------------------
    // Reservation types and power codes
    // ------------------------------------------------------------
    localparam logic [2:0] RT_ALIEN = 3'h0;
    localparam logic [2:0] RT_HARD = 3'h1;
    localparam logic [2:0] RT_SOFT = 3'h2;
    localparam logic [2:0] RT_PRIVATE = 3'h3;
    localparam logic [2:0] RT_PRIO = 3'h4;
    localparam logic [3:0] PW_M2 = 4'he;
    localparam logic [3:0] PW_M1 = 4'hf;
    localparam logic [3:0] PW_0 = 4'h0;
    localparam logic [3:0] PW_P1 = 4'h1;
    localparam logic [3:0] PW_P2 = 4'h2;
    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int AVAIL_WORDS = 8;
    localparam logic [5:0] AVAIL_MAX_OCTETS = 6'h20;
    localparam logic [7:0] RSV_LEN_ONE_ALLOC = 8'h0a;
    localparam logic [7:0] QUIET_LEN = 8'h03;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [31:0] LIMIT_RESET = 32'hffff_ffff;
endpackage : rsv_codec_pkg

/* tb/mac_timing_model.sv */
`timescale 1ns/1ns
module mac_timing_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Superframe timing toward the codec
    output logic superframe_tick,
    output logic [7:0] current_slot
);
    // One slot per clock keeps a superframe at 256 cycles; the tick marks the last slot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            current_slot <= 8'h00;
            superframe_tick <= 1'b0;
        end else begin
            current_slot <= current_slot + 8'h01;
            superframe_tick <= (current_slot == 8'hfe);
        end
    end
endmodule : mac_timing_model

/* tb/codec_port_checker_props.sv */
`timescale 1ns/1ns
module codec_port_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Timing and quiet outputs
    input wire logic [7:0] current_slot,
    input wire logic tx_quiet,
    input wire logic regular_quiet_period_now
);
    import rsv_codec_pkg::*;
    logic [1:0] wr_sel;
    logic od_armed;
    logic [8:0] od_start, od_end;
    logic [7:0] rq_cycle, rq_dur;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // Shadow of the written quiet schedules
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_sel <= 2'h0;
        end else begin
            wr_sel[1] <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == OFS_OD_QUIET);
            wr_sel[0] <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == OFS_REG_QUIET);
        end
    end
    // Valid is only ever armed here; hardware clearing keeps the check one-sided
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            od_armed <= 1'b0;
            od_start <= 9'h000;
            od_end <= 9'h000;
        end else if (wr_sel[1]) begin
            od_armed <= od_armed | hwdata[31];
            od_start <= {1'b0, hwdata[15:8]};
            od_end <= {1'b0, hwdata[15:8]} + {1'b0, hwdata[23:16]};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rq_cycle <= 8'h00;
            rq_dur <= 8'h00;
        end else if (wr_sel[0]) begin
            rq_cycle <= hwdata[15:8];
            rq_dur <= hwdata[23:16];
        end
    end
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    a_ready_always: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
        |-> hrdata == 32'h0) else $error("hrdata outside read data phase");
    a_release_quiet: assert property ($rose(hresetn)
        |-> !tx_quiet && !regular_quiet_period_now) else $error("quiet after reset");
    a_tx_needs_od: assert property (tx_quiet |-> od_armed) else $error("tx_quiet unarmed");
    a_tx_in_window: assert property (tx_quiet |-> {1'b0, $past(current_slot)} >= od_start
        && {1'b0, $past(current_slot)} < od_end) else $error("tx_quiet outside window");
    a_rq_needs_cycle: assert property (regular_quiet_period_now
        |-> rq_cycle != 8'h00) else $error("regular quiet with zero cycle");
    a_rq_in_duration: assert property (regular_quiet_period_now
        |-> $past(current_slot) < rq_dur) else $error("regular quiet past duration");
endmodule : codec_port_checker

bind reservation_ie_field_codec codec_port_checker codec_port_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .current_slot(current_slot),
    .tx_quiet(tx_quiet), .regular_quiet_period_now(regular_quiet_period_now)
);

/* tb/tb_reservation_ie_field_codec.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module tb_reservation_ie_field_codec;
    import rsv_codec_pkg::*;
    logic hclk, hresetn, hsel, hwrite, data_phase, hreadyout, hresp;
    logic superframe_tick, tx_quiet, regular_quiet_period_now;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rnd, e, m;
    logic [7:0] current_slot;
    logic [3:0] z, sl;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    int errors, n_tests, cyc, n_tx, n_rq, t_tx, t_rq;
    // Power code and its expected {dB, valid} status nibble
    logic [3:0] pw_code[6] = '{4'he, 4'hf, 4'h0, 4'h1, 4'h2, 4'h5};
    logic [3:0] pw_stat[6] = '{4'hd, 4'hf, 4'h1, 4'h3, 4'h5, 4'h0};
    logic [31:0] lim_t[3] = '{32'hffff_00ff, 32'hffff_00ff, 32'h7fff_ffff};
    logic [31:0] alc_t[3] = '{32'h0001_0100, 32'h0001_0080, 32'h8000_0001};

    reservation_ie_field_codec reservation_ie_field_codec_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .superframe_tick(superframe_tick), .current_slot(current_slot),
        .tx_quiet(tx_quiet), .regular_quiet_period_now(regular_quiet_period_now)
    );
    mac_timing_model mac_timing_model_inst (.hclk(hclk), .hresetn(hresetn),
        .superframe_tick(superframe_tick), .current_slot(current_slot));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge hclk) begin
        cyc++;
        if (tx_quiet !== 1'b0) n_tx++;
        if (regular_quiet_period_now !== 1'b0) n_rq++;
        if (cyc == 8000) begin
            errors++;
            print_verdict();
        end
    end
    // Read results are compared against the oldest note as they appear
    always @(posedge hclk) begin
        if (data_phase && hreadyout === 1'b1) begin
            e = exp_q.pop_front();
            m = mask_q.pop_front();
            `CHK(hrdata & m, e & m)
        end
    end
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        input logic [31:0] mk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        data_phase <= !w;
        if (!w) begin
            exp_q.push_back(d);
            mask_q.push_back(mk);
        end
        do @(posedge hclk); while (hreadyout !== 1'b1);
        data_phase <= 1'b0;
        hsel <= 1'b0;
        // Idle cycle so a read-back never sees the value before the write
        @(posedge hclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk);
        xfer(a, 1'b0, d, mk);
    endtask : rd
    // Counts quiet cycles over one superframe, tick to tick
    task automatic measure();
        do @(posedge hclk); while (superframe_tick !== 1'b1);
        @(negedge hclk);
        t_tx = n_tx;
        t_rq = n_rq;
        do @(posedge hclk); while (superframe_tick !== 1'b1);
        @(negedge hclk);
        t_tx = n_tx - t_tx;
        t_rq = n_rq - t_rq;
        @(posedge hclk);
    endtask : measure
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, data_phase, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        rnd = 32'd82670;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFS_RSV_WORD, 32'h0000_0001, '1);
        rd(OFS_LIMIT, 32'hffff_ffff, '1);
        rd(OFS_LENGTHS, 32'h0000_030a, '1);
        rd(8'h3c, 32'h0, '1);
        for (int t = 0; t < 5; t++) begin
            wr(OFS_CTRL, 32'(t));
            rd(OFS_RSV_WORD, 32'(t) | ((t == 0 || t == 4) ? 32'h200 : 32'h0), '1);
        end
        wr(OFS_CTRL, 32'h0000_0202);
        rd(OFS_RSV_WORD, 32'h0000_0202, '1);
        rnd = lfsr(rnd);
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_ADDR, rnd);
        rd(OFS_ADDR, rnd, '1);
        wr(OFS_CTRL, 32'h0000_0004);
        rd(OFS_ADDR, 32'h0, '1);
        wr(OFS_CTRL, 32'h0000_3001);
        rd(OFS_STATUS, 32'h8, 32'h8);
        rd(OFS_CTRL, 32'h0000_1001, 32'hffff_fbff);
        rd(OFS_RSV_WORD, 32'h0000_0001, 32'hffff_fbff);
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0, 32'h8);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_LIMIT, lim_t[i]);
            wr(OFS_ALLOC, alc_t[i]);
            rd(OFS_RSV_WORD, (i != 1) ? 32'h800 : 32'h0, 32'h800);
        end
        rnd = lfsr(rnd);
        z = rnd[3:0];
        sl = rnd[7:4];
        wr(OFS_RX_ALLOC, {16'h1 << sl, 16'h1 << z});
        wr(OFS_QUERY, {24'h0, z, sl});
        rd(OFS_STATUS, 32'h1, 32'h1);
        wr(OFS_QUERY, {24'h0, z, sl + 4'h1});
        rd(OFS_STATUS, 32'h0, 32'h1);
        wr(OFS_QUERY, {24'h0, z + 4'h1, sl});
        rd(OFS_STATUS, 32'h0, 32'h1);
        rnd = lfsr(rnd);
        wr(OFS_AVAIL0, rnd);
        wr(OFS_AVAIL_LEN, 32'h2);
        rd(OFS_AVAIL0, rnd & 32'h0000_ffff, '1);
        wr(OFS_QUERY, 32'h11);
        rd(OFS_STATUS, 32'h0, 32'h2);
        wr(OFS_AVAIL_LEN, 32'h28);
        rd(OFS_AVAIL_LEN, 32'h20, '1);
        rd(OFS_STATUS, {30'h0, rnd[17], 1'b0}, 32'h2);
        rnd = lfsr(rnd);
        wr(OFS_LINK_CNT, {24'h0, rnd[7:0]});
        rd(OFS_LINK_CNT, {14'h0, 10'h1 + 10'h3 * {2'h0, rnd[7:0]}, rnd[7:0]}, '1);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_LINK, {8'h0, 4'(i + 9), pw_code[i], rnd[15:0]});
            rd(OFS_STATUS, {20'h0, pw_stat[i], 4'(i + 9), 4'h0}, 32'hff0);
        end
        measure();
        wr(OFS_REG_QUIET, 32'h0004_0301);
        wr(OFS_OD_QUIET, 32'h8004_1001);
        measure();
        `CHK(t_rq, 4)
        `CHK(t_tx, 4)
        rd(OFS_REG_QUIET, 32'h0004_0302, '1);
        rd(OFS_OD_QUIET, 32'h0004_1000, '1);
        measure();
        `CHK(t_rq + t_tx, 0)
        rd(OFS_REG_QUIET, 32'h0004_0300, '1);
        wr(OFS_REG_QUIET, 32'h0004_0000);
        measure();
        `CHK(t_rq, 0)
        print_verdict();
    end
endmodule : tb_reservation_ie_field_codec
